/* File: logic/su1_regs.vh */
`ifndef SU1_REGS_VH
`define SU1_REGS_VH

// Register addresses on the special-function register port
`define SU1_ADDR_RELOAD_LOW 8'hbe
`define SU1_ADDR_RELOAD_HIGH 8'hbf
`define SU1_ADDR_CONTROL 8'hc0
`define SU1_ADDR_DATA_PORT 8'hc1

// Control register fields
`define SU1_CTL_FORMAT 7
`define SU1_CTL_RESERVED 6
`define SU1_CTL_MULTIPROC 5
`define SU1_CTL_RX_ENABLE 4
`define SU1_CTL_TX_NINTH 3
`define SU1_CTL_RX_NINTH 2
`define SU1_CTL_TX_DONE 1
`define SU1_CTL_RX_DONE 0

// Reset values
`define SU1_CONTROL_RESET 8'h00
`define SU1_RELOAD_RESET 10'h000

// Baud timing: one bit is this many reload overflows plus one
`define SU1_OVF_PER_BIT 5'h1f
`define SU1_SAMPLE_POINT 5'h0f
`define SU1_BITS_MODE_A 4'ha
`define SU1_BITS_MODE_B 4'h9

`endif

/* File: logic/su1_uart.v */
`timescale 1ns/1ps
`include "su1_regs.vh"

// Function
// - Control bit 7 picks 9-bit or 8-bit
// - Mode A: start, 8 data, ninth, stop
// - Mode B: start, 8 data, stop
// - Mode A transmit ninth from control bit 3
// - Mode A received ninth into bit 2
// - Mode B stop bit into bit 2
// - Bit 2 reloaded at each frame end; software writes it
// - Receive only while control bit 4 set
// - Transmit done sets bit 1, software clears
// - Receive done sets bit 0, software clears
// - Control bit 5 enables multiprocessor mode in mode A only
// - One data address: write sends, read receives
// - Receive path is double buffered
// - Timing only from 10-bit reload generator
// - Reload assembled from low and high bytes
// - 3FCh at 14.746 MHz gives 115.2k
// - Differential transceiver follows this port
module su1_uart (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Special-function register port
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	// Serial pads and differential transceiver
	input wire rx_pin,
	input wire diff_rx,
	input wire diff_select,
	output reg tx_pin,
	output reg diff_tx,
	output reg diff_tx_oe,
	// Status
	output reg frame_error
);

	reg [7:0] control;
	reg [9:0] reload;
	reg [9:0] baud_cnt;
	reg baud_tick;
	reg [1:0] rx_sync;
	reg [1:0] diff_sync;
	reg [1:0] sel_sync;

	reg tx_busy;
	reg [4:0] tx_ovf;
	reg [3:0] tx_bit;
	reg [10:0] tx_shift;

	reg rx_busy;
	reg [4:0] rx_ovf;
	reg [3:0] rx_bit;
	reg [8:0] rx_shift;
	reg [7:0] rx_hold;
	reg rx_prev;

	wire rx_line;
	wire mode_b;
	wire wr_ctl;
	wire wr_data;
	wire [3:0] last_bit;
	wire rx_sample;
	wire rx_stop;
	wire rx_accept;
	wire tx_finish;
	reg [7:0] next_rdata;

	assign mode_b = control[`SU1_CTL_FORMAT];
	assign last_bit = mode_b ? `SU1_BITS_MODE_B : `SU1_BITS_MODE_A;
	assign wr_ctl = sfr_wr && (sfr_addr == `SU1_ADDR_CONTROL);
	assign wr_data = sfr_wr && (sfr_addr == `SU1_ADDR_DATA_PORT);
	// Only the second stage of each synchroniser is looked at
	assign rx_line = sel_sync[1] ? diff_sync[1] : rx_sync[1];
	assign rx_sample = rx_busy && baud_tick && (rx_ovf == `SU1_SAMPLE_POINT);
	assign rx_stop = rx_sample && (rx_bit == last_bit);
	// Multiprocessor filter drops frames whose ninth bit is zero
	assign rx_accept = !(control[`SU1_CTL_MULTIPROC] && !mode_b && !rx_shift[8]);
	assign tx_finish = tx_busy && baud_tick && (tx_ovf == `SU1_OVF_PER_BIT) && (tx_bit == last_bit);

	// Pad synchronisers
	always @(posedge clk) begin
		if (!nrst) begin
			rx_sync <= 2'h3;
			diff_sync <= 2'h3;
			sel_sync <= 2'h0;
		end else begin
			rx_sync <= {rx_sync[0], rx_pin};
			diff_sync <= {diff_sync[0], diff_rx};
			sel_sync <= {sel_sync[0], diff_select};
		end
	end

	// Reload generator: counts up from reload to 3FFh, one tick per wrap
	always @(posedge clk) begin
		if (!nrst) begin
			baud_cnt <= `SU1_RELOAD_RESET;
			baud_tick <= 1'b0;
		end else if (baud_cnt == 10'h3ff) begin
			baud_cnt <= reload;
			baud_tick <= 1'b1;
		end else begin
			baud_cnt <= baud_cnt + 10'h001;
			baud_tick <= 1'b0;
		end
	end

	// Registers written by software
	always @(posedge clk) begin
		if (!nrst) begin
			reload <= `SU1_RELOAD_RESET;
			control <= `SU1_CONTROL_RESET;
		end else begin
			if (sfr_wr && sfr_addr == `SU1_ADDR_RELOAD_LOW)
				reload[7:0] <= sfr_wdata;
			if (sfr_wr && sfr_addr == `SU1_ADDR_RELOAD_HIGH)
				reload[9:8] <= sfr_wdata[1:0];
			if (wr_ctl) begin
				control[7] <= sfr_wdata[7];
				control[5:3] <= sfr_wdata[5:3];
			end
			// Hardware set beats a software clear in the same cycle
			if (rx_stop && control[`SU1_CTL_RX_ENABLE]) begin
				control[`SU1_CTL_RX_NINTH] <= mode_b ? rx_line : rx_shift[8];
			end else if (wr_ctl) begin
				control[`SU1_CTL_RX_NINTH] <= sfr_wdata[2];
			end
			if (tx_finish)
				control[`SU1_CTL_TX_DONE] <= 1'b1;
			else if (wr_ctl && !sfr_wdata[1])
				control[`SU1_CTL_TX_DONE] <= 1'b0;
			if (rx_stop && control[`SU1_CTL_RX_ENABLE] && rx_accept)
				control[`SU1_CTL_RX_DONE] <= 1'b1;
			else if (wr_ctl && !sfr_wdata[0])
				control[`SU1_CTL_RX_DONE] <= 1'b0;
		end
	end

	// Transmitter; a write while busy restarts the frame with the new byte
	always @(posedge clk) begin
		if (!nrst) begin
			tx_busy <= 1'b0;
			tx_ovf <= 5'h00;
			tx_bit <= 4'h0;
			tx_shift <= 11'h7ff;
			tx_pin <= 1'b1;
			diff_tx <= 1'b1;
			diff_tx_oe <= 1'b0;
		end else begin
			if (wr_data) begin
				// Stop bit high, ninth from control bit 3
				tx_shift <= {1'b1, control[`SU1_CTL_TX_NINTH], sfr_wdata, 1'b0};
				tx_busy <= 1'b1;
				tx_ovf <= 5'h00;
				tx_bit <= 4'h0;
			end else if (tx_busy && baud_tick) begin
				tx_ovf <= tx_ovf + 5'h01;
				if (tx_ovf == `SU1_OVF_PER_BIT) begin
					if (tx_bit == last_bit) begin
						tx_busy <= 1'b0;
						tx_shift <= 11'h7ff;
					end else begin
						tx_bit <= tx_bit + 4'h1;
						// Mode B skips the ninth slot straight to stop
						if (mode_b && tx_bit == 4'h8)
							tx_shift <= {1'b1, tx_shift[10:2]};
						else
							tx_shift <= {1'b1, tx_shift[10:1]};
					end
				end
			end
			tx_pin <= tx_busy ? tx_shift[0] : 1'b1;
			diff_tx <= tx_busy ? tx_shift[0] : 1'b1;
			diff_tx_oe <= tx_busy && sel_sync[1];
		end
	end

	// Receiver: start on falling edge, sample mid-bit
	always @(posedge clk) begin
		if (!nrst) begin
			rx_busy <= 1'b0;
			rx_ovf <= 5'h00;
			rx_bit <= 4'h0;
			rx_shift <= 9'h000;
			rx_hold <= 8'h00;
			rx_prev <= 1'b1;
			frame_error <= 1'b0;
		end else begin
			rx_prev <= rx_line;
			if (!control[`SU1_CTL_RX_ENABLE]) begin
				rx_busy <= 1'b0;
			end else if (!rx_busy) begin
				if (rx_prev && !rx_line) begin
					rx_busy <= 1'b1;
					rx_ovf <= 5'h00;
					rx_bit <= 4'h0;
				end
			end else if (baud_tick) begin
				rx_ovf <= rx_ovf + 5'h01;
				if (rx_sample) begin
					if (rx_bit == 4'h0 && rx_line) begin
						rx_busy <= 1'b0;
					end else if (rx_bit == last_bit) begin
						rx_busy <= 1'b0;
						frame_error <= !rx_line;
						// Holding byte changes only on completion
						if (rx_accept)
							rx_hold <= rx_shift[7:0];
					end else if (rx_bit != 4'h0) begin
						rx_shift <= {rx_line, rx_shift[8:1]};
					end
				end
				if (rx_ovf == `SU1_OVF_PER_BIT)
					rx_bit <= rx_bit + 4'h1;
			end
			// Mode B has no ninth bit: realign byte to the low end
			if (rx_sample && mode_b && rx_bit == 4'h8)
				rx_shift <= {1'b0, rx_line, rx_shift[8:2]};
		end
	end

	// Read mux; unmapped addresses return zero, reserved bit reads zero
	always @* begin
		case (sfr_addr)
			`SU1_ADDR_RELOAD_LOW: next_rdata = reload[7:0];
			`SU1_ADDR_RELOAD_HIGH: next_rdata = {6'h00, reload[9:8]};
			`SU1_ADDR_CONTROL: next_rdata = control;
			`SU1_ADDR_DATA_PORT: next_rdata = rx_hold;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
			sfr_rdata <= next_rdata;
	end

endmodule // su1_uart

/* File: verification/su1_chk.sv */
`timescale 1ns/1ps
module su1_chk(input wire clk, input wire nrst, input wire [7:0] sfr_addr, input wire sfr_wr,
	input wire sfr_rd, input wire [7:0] sfr_wdata, input wire [7:0] sfr_rdata, input wire tx_pin,
	input wire diff_tx, input wire diff_tx_oe, input wire diff_select);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_wr(a); sfr_wr && sfr_addr == a; endsequence
	sequence s_rd(a); sfr_rd && sfr_addr == a; endsequence
	property p_zero; sfr_rd && sfr_addr < 8'hbe |=> sfr_rdata == 8'h00; endproperty
	a_zero: assert property (p_zero) else $error("bad unmapped");
	property p_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
	property p_bit6; s_rd(8'hc0) |=> !sfr_rdata[6]; endproperty
	a_bit6: assert property (p_bit6) else $error("bit6 set");
	property p_start; s_wr(8'hc1) |-> ##[1:3] !tx_pin; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_copy; tx_pin == diff_tx; endproperty
	a_copy: assert property (p_copy) else $error("diff differs");
	// Selection is synchronised, so allow its latency first
	property p_oe; !diff_select [*4] |-> !diff_tx_oe; endproperty
	a_oe: assert property (p_oe) else $error("oe unselected");
	property p_reload; s_wr(8'hbe) ##1 s_rd(8'hbe) |=> sfr_rdata == $past(sfr_wdata, 2); endproperty
	a_reload: assert property (p_reload) else $error("reload");
	property p_ctl; s_wr(8'hc0) ##1 s_rd(8'hc0) |=> sfr_rdata[5:3] == $past(sfr_wdata[5:3], 2); endproperty
	a_ctl: assert property (p_ctl) else $error("control");
endmodule // su1_chk
bind su1_uart su1_chk i_su1_chk(.*);

/* File: verification/su1_node.sv */
`timescale 1ns/1ps
module su1_node(input wire clk, input wire tx, output logic line);
	initial line = 1'b1;
	// Reload 3ffh gives 32 clocks per bit
	task send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			line = f[i];
			repeat (32) @(negedge clk);
		end
		line = 1'b1;
	endtask
	task get(output logic [10:0] f);
		@(negedge tx);
		repeat (16) @(negedge clk);
		for (int i = 0; i < 11; i++) begin
			f[i] = tx;
			repeat (32) @(negedge clk);
		end
	endtask
endmodule // su1_node

/* File: verification/second_uart_with_reload_baud_tb.sv */
`timescale 1ns/1ps
module second_uart_with_reload_baud_tb;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, dsel = 0, line, tx, ferr, b;
	logic [7:0] addr = 0, wdata = 0, rdata, c, d;
	logic [10:0] f;
	int failures = 0, n_compared = 0, m;
	initial forever #4 clk = ~clk;
	// The unselected input sits low, so a wrong route shows as a false start
	su1_uart i_su1_uart(.clk(clk), .nrst(nrst), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_wdata(wdata), .sfr_rdata(rdata), .rx_pin(dsel ? 1'b0 : line), .diff_rx(dsel ? line : 1'b0),
		.diff_select(dsel), .tx_pin(tx), .diff_tx(), .diff_tx_oe(), .frame_error(ferr));
	su1_node i_su1_node(.clk(clk), .tx(tx), .line(line));
	task chk(input logic [10:0] g, x);
		n_compared++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task wrr(input logic [7:0] a, v);
		addr = a; wdata = v; wr = 1;
		@(negedge clk) wr = 0;
	endtask
	task rdd(input logic [7:0] a);
		addr = a; rd = 1;
		@(negedge clk) rd = 0;
		@(negedge clk) c = rdata;
	endtask
	function logic [10:0] fr(input logic [7:0] v, input logic n9);
		return m ? {2'b11, v, 1'b0} : {1'b1, n9, v, 1'b0};
	endfunction
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#150000;
		failures++;
		report_and_stop;
	end
	initial begin
		void'($urandom(97302));
		repeat (12) @(negedge clk);
		nrst = 1;
		wrr(8'hbf, 8'h03);
		wrr(8'hbe, 8'hff);
		rdd(8'hbe); chk(c, 8'hff);
		rdd(8'h50); chk(c, 0);
		// The reload counter starts at zero, so ticks begin only after its first wrap
		repeat (1100) @(negedge clk);
		for (int i = 0; i < 4; i++) begin
			m = i % 2;
			wrr(8'hc0, 8'h00);
			dsel = i / 2;
			repeat (4) @(negedge clk);
			d = $urandom; b = $urandom;
			wrr(8'hc0, {m[0], 3'b001, b, 3'b000});
			wrr(8'hc1, d);
			i_su1_node.get(f);
			chk(f, fr(d, b));
			rdd(8'hc0); chk(c[1], 1);
			wrr(8'hc0, {m[0], 3'b001, b, 3'b000});
			rdd(8'hc0); chk(c[1:0], 0);
			d = $urandom; b = $urandom;
			i_su1_node.send(fr(d, b), 11 - m);
			repeat (8) @(negedge clk);
			rdd(8'hc0); chk(c[2:0], {m ? 1'b1 : b, 2'b01});
			rdd(8'hc1); chk(c, d);
			$display("case %0d done", i);
		end
		wrr(8'hc0, 8'h80);
		i_su1_node.send(fr(8'h5a, 1), 10);
		rdd(8'hc0); chk(c[0], 0);
		rdd(8'hc1); chk(c, d);
		wrr(8'hc0, 8'h90);
		i_su1_node.send({2'b00, 8'ha5, 1'b0}, 10);
		chk(ferr, 1);
		rdd(8'hc0); chk(c[2], 0);
		$display("refusal cases done");
		m = 0;
		wrr(8'hc0, 8'h30);
		i_su1_node.send(fr(8'hc3, 0), 11);
		rdd(8'hc0); chk(c[0], 0);
		i_su1_node.send(fr(8'h3c, 1), 11);
		rdd(8'hc0); chk(c[2:0], 3'b101);
		rdd(8'hc1); chk(c, 8'h3c);
		$display("multiprocessor case done");
		report_and_stop;
	end
endmodule // second_uart_with_reload_baud_tb
